// ---- drlc_board.sv ----
// drlc_board: board-side model of the pins around the logic cell array.
// assumes the bench chooses the levels the board puts on undriven pins.
`timescale 1ns/1ps
`default_nettype none
module drlc_board (
    input  wire logic       busy,
    input  wire logic [9:0] io_out,
    input  wire logic [9:0] io_oe,
    input  wire logic [9:0] board_drive,
    input  wire logic       pin_clk_lvl,
    output logic      [9:0] io_in,
    output logic            clock_pin
);
    // ==================================================
    // pin resolution
    // the device wins where it drives; elsewhere the board level shows
    assign io_in = (io_oe & io_out) | (~io_oe & board_drive);
    // clock pin kept still during the clear, edges only once setup is met
    assign clock_pin = pin_clk_lvl & ~busy;
endmodule // drlc_board
`default_nettype wire

// ---- drlc_pkg.sv ----
// drlc_pkg: constants for the dual-register logic cell array.
// assumes a single 100 MHz system clock; all pins are sampled by the top module.
package drlc_pkg;
    localparam int CELLS           = 10;
    localparam int REGS            = 20;
    localparam int SIG_W           = 64;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int PUC_NS          = 1000;
    // longest time rounds down, at least one cycle
    localparam int PUC_CYC_RAW     = PUC_NS / CLK_PERIOD_NS;
    localparam int PUC_CYCLES      = (PUC_CYC_RAW < 1) ? 1 : PUC_CYC_RAW;
    localparam int PUC_W           = 8;
    localparam logic [REGS-1:0] REG_RESET = 20'h00000;
    localparam logic [SIG_W-1:0] SIG_RESET = 64'h0000000000000000;
    localparam logic [SIG_W-1:0] SIG_ALL_PROG = 64'hFFFFFFFFFFFFFFFF;
endpackage

// ---- drlc_top.sv ----
// drlc_top: twenty-register output logic cell array with preload, preset and security.
// assumes sum, reset and clock terms come from an array outside; pins are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module drlc_top (
    input  wire logic                          clock,
    input  wire logic                          reset,
    input  wire logic [drlc_pkg::REGS-1:0]     sum_term,
    input  wire logic [drlc_pkg::REGS-1:0]     reset_term,
    input  wire logic [drlc_pkg::REGS-1:0]     clock_term,
    input  wire logic [drlc_pkg::REGS-1:0]     t_type_cfg,
    input  wire logic [drlc_pkg::REGS-1:0]     pin_clock_cfg,
    input  wire logic [drlc_pkg::CELLS-1:0]    out_polarity_cfg,
    input  wire logic [drlc_pkg::CELLS-1:0]    oe_term,
    input  wire logic                          subset_mode,
    input  wire logic                          sync_preset,
    input  wire logic                          clock_pin,
    input  wire logic                          preload_mode,
    input  wire logic                          preload_select,
    input  wire logic [drlc_pkg::CELLS-1:0]    io_in,
    input  wire logic                          keeper_cfg_wr,
    input  wire logic                          keeper_cfg_val,
    input  wire logic                          signature_wr,
    input  wire logic [drlc_pkg::SIG_W-1:0]    signature_val,
    input  wire logic                          security_program,
    input  wire logic                          verify_fuse,
    output logic      [drlc_pkg::CELLS-1:0]    io_out,
    output logic      [drlc_pkg::CELLS-1:0]    io_oe,
    output logic      [drlc_pkg::REGS-1:0]     feedback,
    output logic      [drlc_pkg::CELLS-1:0]    pin_feedback,
    output logic                               pin_keeper_en,
    output logic      [drlc_pkg::SIG_W-1:0]    user_signature_row,
    output logic                               verify_data,
    output logic                               power_up_clear_busy
);
    // ==========================================================
    // pin synchronisers: three stages, change once stages 2 and 3 agree
    // ==========================================================
    localparam int SW = drlc_pkg::CELLS + 5;
    logic [SW-1:0] s1_q, s2_q, s3_q, pin_q, s1_d, s2_d, s3_d, pin_d;
    always_comb begin
        s1_d  = {clock_pin, preload_mode, preload_select, sync_preset, verify_fuse, io_in};
        s2_d  = s1_q;
        s3_d  = s2_q;
        pin_d = pin_q;
        for (int i = 0; i < SW; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                pin_d[i] = s3_q[i];
            end
        end
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            pin_q <= '0;
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            pin_q <= pin_d;
        end
    end
    logic [drlc_pkg::CELLS-1:0] io_s;
    logic pclk_s, pl_mode_s, pl_sel_s, preset_s, verify_s;
    assign io_s      = pin_q[drlc_pkg::CELLS-1:0];
    assign verify_s  = pin_q[drlc_pkg::CELLS];
    assign preset_s  = pin_q[drlc_pkg::CELLS+1];
    assign pl_sel_s  = pin_q[drlc_pkg::CELLS+2];
    assign pl_mode_s = pin_q[drlc_pkg::CELLS+3];
    assign pclk_s    = pin_q[drlc_pkg::CELLS+4];

    // ==========================================================
    // power-up clear interval counter
    // ==========================================================
    logic [drlc_pkg::PUC_W-1:0] puc_q, puc_d;
    logic                       busy_q, busy_d;
    always_comb begin
        puc_d  = puc_q;
        busy_d = 1'b0;
        // stop one short so busy stands exactly PUC_CYCLES edges and stays inside the longest interval
        if (puc_q != drlc_pkg::PUC_W'(drlc_pkg::PUC_CYCLES - 1)) begin
            puc_d  = puc_q + 1'b1;
            busy_d = 1'b1;
        end
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            puc_q  <= '0;
            busy_q <= 1'b1;
        end else begin
            puc_q  <= puc_d;
            busy_q <= busy_d;
        end
    end

    // ==========================================================
    // clock edge detection per register
    // ==========================================================
    logic [drlc_pkg::REGS-1:0] clk_sel, clk_prev_q, clk_prev_d, clk_rise;
    logic [drlc_pkg::REGS-1:0] ff_q, ff_d;
    logic [drlc_pkg::REGS-1:0] keep_next;
    genvar g;
    generate
        for (g = 0; g < drlc_pkg::REGS; g++) begin : g_reg
            // two registers per cell: even index first, odd index second
            localparam int CELL = g / 2;
            localparam bit SECOND = (g % 2) == 1;
            logic use_t;
            // subset mode strips T-type and pin clocking
            assign use_t      = t_type_cfg[g] & ~subset_mode;
            assign clk_sel[g] = (pin_clock_cfg[g] & ~subset_mode) ? pclk_s : clock_term[g];
            assign clk_rise[g] = clk_sel[g] & ~clk_prev_q[g];
            always_comb begin
                ff_d[g] = ff_q[g];
                if (busy_q) begin
                    ff_d[g] = 1'b0;
                end else if (reset_term[g]) begin
                    ff_d[g] = 1'b0;
                end else if (pl_mode_s) begin
                    // polarity is ignored while forcing state
                    if (clk_rise[g] && (pl_sel_s == SECOND)) begin
                        ff_d[g] = io_s[CELL];
                    end
                end else if (clk_rise[g]) begin
                    if (preset_s) begin
                        ff_d[g] = 1'b1;
                    end else if (use_t) begin
                        ff_d[g] = ff_q[g] ^ sum_term[g];
                    end else begin
                        ff_d[g] = sum_term[g];
                    end
                end
            end
            // second-register feedback is gated off in subset mode
            assign keep_next[g] = (SECOND && subset_mode) ? 1'b0 : ff_d[g];
        end
    endgenerate
    assign clk_prev_d = clk_sel;

    // ==========================================================
    // pins, feedback and configuration outputs
    // ==========================================================
    logic [drlc_pkg::CELLS-1:0] out_d, out_q, oe_d, oe_q, pfb_d, pfb_q;
    logic [drlc_pkg::REGS-1:0]  fb_q;
    logic                       keeper_q, keeper_d, sec_q, sec_d, vdat_q, vdat_d;
    logic [drlc_pkg::SIG_W-1:0] sig_q, sig_d;
    always_comb begin
        for (int c = 0; c < drlc_pkg::CELLS; c++) begin
            out_d[c] = ff_d[2*c] ^ out_polarity_cfg[c];
        end
        keeper_d = keeper_cfg_wr ? keeper_cfg_val : keeper_q;
        sig_d    = signature_wr ? signature_val : sig_q;
        sec_d    = sec_q | security_program;
        // once secured, every fuse reads as programmed at once
        vdat_d   = sec_d ? 1'b1 : verify_s;
        // output drivers are off while preload forces pins from outside
        oe_d     = oe_term & {drlc_pkg::CELLS{~pl_mode_s}};
        pfb_d    = io_s;
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            clk_prev_q <= drlc_pkg::REG_RESET;
            ff_q       <= drlc_pkg::REG_RESET;
            fb_q       <= drlc_pkg::REG_RESET;
            out_q      <= '0;
            oe_q       <= '0;
            pfb_q      <= '0;
            keeper_q   <= 1'b0;
            sig_q      <= drlc_pkg::SIG_RESET;
            sec_q      <= 1'b0;
            vdat_q     <= 1'b0;
        end else begin
            clk_prev_q <= clk_prev_d;
            ff_q       <= ff_d;
            fb_q       <= keep_next;
            out_q      <= out_d;
            oe_q       <= oe_d;
            pfb_q      <= pfb_d;
            keeper_q   <= keeper_d;
            sig_q      <= sig_d;
            sec_q      <= sec_d;
            vdat_q     <= vdat_d;
        end
    end
    assign io_out              = out_q;
    assign io_oe               = oe_q;
    assign feedback            = fb_q;
    assign pin_feedback        = pfb_q;
    assign pin_keeper_en       = keeper_q;
    assign user_signature_row  = sig_q;
    assign verify_data         = vdat_q;
    assign power_up_clear_busy = busy_q;

    // ==========================================================
    // assertions
    // ==========================================================
    property p_clear_hold;
        @(posedge clock) disable iff (reset) busy_q |=> (ff_q == '0);
    endproperty
    a_clear_hold: assert property (p_clear_hold) else $error("register set during clear");
    property p_clear_len;
        @(posedge clock) disable iff (reset)
            $fell(busy_q) |-> $past(puc_q) == drlc_pkg::PUC_W'(drlc_pkg::PUC_CYCLES - 1);
    endproperty
    a_clear_len: assert property (p_clear_len) else $error("clear interval wrong");
    property p_pol0;
        @(posedge clock) disable iff (reset) ##1 (io_out[0] == (ff_q[0] ^ $past(out_polarity_cfg[0])));
    endproperty
    a_pol0: assert property (p_pol0) else $error("pin polarity wrong");
    property p_async_clr;
        @(posedge clock) disable iff (reset) reset_term[3] |=> !ff_q[3];
    endproperty
    a_async_clr: assert property (p_async_clr) else $error("reset term ignored");
    property p_preset;
        @(posedge clock) disable iff (reset)
            !busy_q && !reset_term[4] && !pl_mode_s && preset_s && clk_rise[4] |=> ff_q[4];
    endproperty
    a_preset: assert property (p_preset) else $error("preset missed");
    logic use_t1;
    assign use_t1 = t_type_cfg[1] & ~subset_mode;
    property p_toggle;
        @(posedge clock) disable iff (reset)
            !busy_q && !reset_term[1] && !pl_mode_s && !preset_s && clk_rise[1] && use_t1 && sum_term[1]
            |=> ff_q[1] != $past(ff_q[1]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("T register did not toggle");
    property p_hold;
        @(posedge clock) disable iff (reset) !clk_rise[2] && !busy_q && !reset_term[2] |=> $stable(ff_q[2]);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without edge");
    property p_preload;
        @(posedge clock) disable iff (reset)
            !busy_q && !reset_term[5] && pl_mode_s && pl_sel_s && clk_rise[5] |=> ff_q[5] == $past(io_s[2]);
    endproperty
    a_preload: assert property (p_preload) else $error("preload wrong register");
    property p_secure;
        @(posedge clock) disable iff (reset) sec_q |-> ##1 verify_data;
    endproperty
    a_secure: assert property (p_secure) else $error("secured fuse read unprogrammed");
    property p_subset_fb;
        @(posedge clock) disable iff (reset) subset_mode |=> !feedback[1];
    endproperty
    a_subset_fb: assert property (p_subset_fb) else $error("second feedback in subset mode");
    // loads with the select pin low go to the first register of the cell
    property p_preload_low;
        @(posedge clock) disable iff (reset)
            !busy_q && !reset_term[4] && pl_mode_s && !pl_sel_s && clk_rise[4] |=> ff_q[4] == $past(io_s[2]);
    endproperty
    a_preload_low: assert property (p_preload_low) else $error("preload missed first register");
    property p_dtype;
        @(posedge clock) disable iff (reset)
            !busy_q && !reset_term[0] && !pl_mode_s && !preset_s && clk_rise[0] && !(t_type_cfg[0] && !subset_mode)
            |=> ff_q[0] == $past(sum_term[0]);
    endproperty
    a_dtype: assert property (p_dtype) else $error("D register did not load sum term");
    property p_subset_t;
        @(posedge clock) disable iff (reset)
            !busy_q && !reset_term[1] && !pl_mode_s && !preset_s && clk_rise[1] && subset_mode
            |=> ff_q[1] == $past(sum_term[1]);
    endproperty
    a_subset_t: assert property (p_subset_t) else $error("T operation in subset mode");
    // watches the synchronised pin directly, so a wrong clock select is caught
    property p_pin_clock;
        @(posedge clock) disable iff (reset)
            !busy_q && !reset_term[6] && !pl_mode_s && !preset_s && !t_type_cfg[6] && pclk_s && !$past(pclk_s)
            && pin_clock_cfg[6] && !subset_mode && $past(pin_clock_cfg[6] & ~subset_mode)
            |=> ff_q[6] == $past(sum_term[6]);
    endproperty
    a_pin_clock: assert property (p_pin_clock) else $error("pin clock edge missed");
    property p_oe_preload;
        @(posedge clock) disable iff (reset) pl_mode_s |=> io_oe == '0;
    endproperty
    a_oe_preload: assert property (p_oe_preload) else $error("pin driven during preload");
    property p_oe_follow;
        @(posedge clock) disable iff (reset) !pl_mode_s |=> io_oe == $past(oe_term);
    endproperty
    a_oe_follow: assert property (p_oe_follow) else $error("output enable term not followed");
    property p_fb_match;
        @(posedge clock) disable iff (reset) !subset_mode |=> feedback == ff_q;
    endproperty
    a_fb_match: assert property (p_fb_match) else $error("feedback differs from registers");
    property p_pin_fb;
        @(posedge clock) disable iff (reset) 1'b1 |=> pin_feedback == $past(io_s);
    endproperty
    a_pin_fb: assert property (p_pin_fb) else $error("pin input path wrong");
    property p_keeper_wr;
        @(posedge clock) disable iff (reset) keeper_cfg_wr |=> pin_keeper_en == $past(keeper_cfg_val);
    endproperty
    a_keeper_wr: assert property (p_keeper_wr) else $error("keeper bit not written");
    property p_sig_wr;
        @(posedge clock) disable iff (reset) signature_wr |=> user_signature_row == $past(signature_val);
    endproperty
    a_sig_wr: assert property (p_sig_wr) else $error("signature row not written");
    property p_sec_sticky;
        @(posedge clock) disable iff (reset) sec_q |=> sec_q;
    endproperty
    a_sec_sticky: assert property (p_sec_sticky) else $error("security fuse cleared");

    // ==========================================================
    // cover points
    // ==========================================================
    c_preload:   cover property (@(posedge clock) pl_mode_s && clk_rise[0]);
    c_preset:    cover property (@(posedge clock) preset_s && clk_rise[0] && !busy_q);
    c_secure:    cover property (@(posedge clock) $rose(sec_q));
    c_toggle:    cover property (@(posedge clock) !busy_q && clk_rise[1] && use_t1 && sum_term[1]);
    c_pin_clock: cover property (@(posedge clock) !busy_q && pin_clock_cfg[0] && clk_rise[0]);
endmodule // drlc_top
`default_nettype wire

// ---- dual_register_logic_cell_bench.sv ----
// dual_register_logic_cell_bench: random and corner tests of the register cell array.
// assumes drlc_top with the package constants and the board model beside it.
`timescale 1ns/1ps
`default_nettype none
module dual_register_logic_cell_bench;
    logic        clock = 1'b0, reset = 1'b1;
    logic [19:0] sum_term = '0, reset_term = '0, clock_term = '0, t_type_cfg = '0, pin_clock_cfg = '0;
    logic [9:0]  out_polarity_cfg = '0, oe_term = '0, board_drive = '0;
    logic        subset_mode = 0, sync_preset = 0, pin_clk_lvl = 0, preload_mode = 0, preload_select = 0;
    logic        keeper_cfg_wr = 0, keeper_cfg_val = 0, signature_wr = 0, security_program = 0, verify_fuse = 0;
    logic [63:0] signature_val = '0;
    logic [9:0]  io_in, io_out, io_oe, pin_feedback;
    logic [19:0] feedback;
    logic [63:0] user_signature_row;
    logic        clock_pin, pin_keeper_en, verify_data, power_up_clear_busy;
    int          failures = 0, n_checks = 0;
    logic [19:0] m;

    drlc_top dut_u (.clock, .reset, .sum_term, .reset_term, .clock_term, .t_type_cfg, .pin_clock_cfg,
        .out_polarity_cfg, .oe_term, .subset_mode, .sync_preset, .clock_pin, .preload_mode, .preload_select,
        .io_in, .keeper_cfg_wr, .keeper_cfg_val, .signature_wr, .signature_val, .security_program,
        .verify_fuse, .io_out, .io_oe, .feedback, .pin_feedback, .pin_keeper_en, .user_signature_row,
        .verify_data, .power_up_clear_busy);
    drlc_board board_u (.busy(power_up_clear_busy), .io_out, .io_oe, .board_drive, .pin_clk_lvl, .io_in,
        .clock_pin);

    initial forever #5 clock = ~clock;

    // ==================================================
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one rising transition on every clock term; feedback settles on the next edge
    task automatic pulse();
        clock_term <= '0;
        step(1);
        clock_term <= '1;
        step(3);
        #1;
    endtask
    function automatic logic [19:0] nxt(logic [19:0] o, logic [19:0] s, logic [19:0] t);
        return (t & (o ^ s)) | (~t & s);
    endfunction
    function automatic logic [9:0] evn(logic [19:0] v);
        for (int c = 0; c < 10; c++) evn[c] = v[2*c];
    endfunction

    // ==================================================
    // main sequence
    initial begin
        int i;
        logic [19:0] s, t;
        logic [9:0]  b;
        void'($urandom(32'h42C2));
        out_polarity_cfg = 10'($urandom);
        step(2);
        reset <= 1'b0;
        for (i = 1; i <= 200; i++) begin
            step(1);
            #1;
            if (power_up_clear_busy === 1'b0) break;
        end
        if (i > 200) begin
            failures++;
            report_and_stop();
        end
        chk("clear_length", 64'(i >= 99 && i <= 101), 64'h1);
        chk("feedback_after_clear", 64'(feedback), 64'h0);
        chk("io_out_after_clear", 64'(io_out), 64'(out_polarity_cfg));
        m = '0;
        step(5);
        for (int k = 0; k < 16; k++) begin
            s = k == 0 ? 20'hFFFFF : 20'($urandom);
            t = k == 1 ? 20'hFFFFF : 20'($urandom);
            sum_term <= s;
            t_type_cfg <= t;
            pulse();
            m = nxt(m, s, t);
            chk("feedback_dt", 64'(feedback), 64'(m));
            chk("io_out_dt", 64'(io_out), 64'(evn(m) ^ out_polarity_cfg));
            s = 20'($urandom);
            reset_term <= s;
            step(2);
            #1;
            chk("feedback_reset_term", 64'(feedback), 64'(m & ~s));
            m = m & ~s;
            reset_term <= '0;
        end
        sync_preset <= 1'b1;
        step(6);
        pulse();
        chk("feedback_preset", 64'(feedback), 64'hFFFFF);
        sync_preset <= 1'b0;
        s = 20'($urandom);
        sum_term <= s;
        t_type_cfg <= '0;
        pin_clock_cfg <= 20'h0FFFF;
        step(6);
        pin_clk_lvl <= 1'b1;
        step(8);
        #1;
        chk("feedback_pin_clock", 64'(feedback), 64'({4'hF, s[15:0]}));
        pin_clk_lvl <= 1'b0;
        pin_clock_cfg <= '0;
        subset_mode <= 1'b1;
        t_type_cfg <= '1;
        s = 20'($urandom);
        sum_term <= s;
        pulse();
        chk("feedback_subset", 64'(feedback), 64'(s & 20'h55555));
        subset_mode <= 1'b0;
        t_type_cfg <= '0;
        b = 10'($urandom);
        oe_term <= b;
        step(3);
        #1;
        chk("io_oe", 64'(io_oe), 64'(b));
        for (int sel = 0; sel < 2; sel++) begin
            b = 10'($urandom);
            board_drive <= b;
            preload_mode <= 1'b1;
            preload_select <= sel[0];
            // drivers go off only after the mode is synchronised; the freed pins then need their own sync
            step(12);
            #1;
            chk("io_oe_preload", 64'(io_oe), 64'h0);
            chk("pin_feedback", 64'(pin_feedback), 64'(b));
            pulse();
            for (int c = 0; c < 10; c++) chk("preload_reg", 64'(feedback[2*c+sel]), 64'(b[c]));
            preload_mode <= 1'b0;
            step(6);
        end
        keeper_cfg_val <= 1'b1;
        keeper_cfg_wr <= 1'b1;
        signature_val <= {$urandom, $urandom};
        signature_wr <= 1'b1;
        verify_fuse <= 1'b1;
        step(1);
        keeper_cfg_wr <= 1'b0;
        signature_wr <= 1'b0;
        step(2);
        #1;
        chk("keeper", 64'(pin_keeper_en), 64'h1);
        chk("signature", user_signature_row, signature_val);
        step(5);
        #1;
        chk("verify_fuse", 64'(verify_data), 64'h1);
        verify_fuse <= 1'b0;
        step(7);
        #1;
        chk("verify_open", 64'(verify_data), 64'h0);
        security_program <= 1'b1;
        step(1);
        security_program <= 1'b0;
        step(3);
        #1;
        chk("verify_secured", 64'(verify_data), 64'h1);
        report_and_stop();
    end
endmodule // dual_register_logic_cell_bench
`default_nettype wire
